// ===== rtl/psb_iface.sv
// Asynchronous and page-mode bus interface of the pseudo-static RAM die.
//
// Functional notes
// - Read: CE, OE, byte enable low, WE high.
// - Write: CE, WE, byte enable low together.
// - Write ignores OE; data pins stay undriven.
// - Write data latched on first rising strobe.
// - Wait driven under chip select; controller ignores.
// - Asynchronous mode after power-up until reconfigured.
// - 150 us self-initialisation loads register defaults.
// - Page mode: low four address bits, faster.
// - Page reads only with refresh bit 7 set.
// - Writes never use page mode.
// - Byte enables pick data lanes.
// - Bus config bit 10 sets wait polarity.
// - Burst only when bus config bit 15 clear.
// - Chip select high: standby, outputs float.
// - Deep power-down holds until refresh config write; code leaves it on any config register write.
// - Config select write loads configuration register.
// - Both byte enables high: no data transfer.
`timescale 1ns/1ps
`include "psb_map.svh"

module psb_iface #(
  parameter int INIT_CYCLES   = `PSB_INIT_CYCLES,
  parameter int ACCESS_CYCLES = `PSB_ACCESS_CYCLES,
  parameter int PAGE_CYCLES   = `PSB_PAGE_CYCLES
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  // Controller strobes and address
  input  wire logic        I_CE_N,
  input  wire logic        I_OE_N,
  input  wire logic        I_WE_N,
  input  wire logic        I_LOW_BYTE_SEL_N,
  input  wire logic        I_HIGH_BYTE_SEL_N,
  input  wire logic        I_ADDR_VALID_N,
  input  wire logic        I_CFG_REG_SELECT,
  input  wire logic [22:0] I_ADDR,
  // Data pins
  input  wire logic [15:0] I_DQ,
  output logic      [15:0] O_DQ,
  output logic      [1:0]  O_DQ_OE,
  // Wait pin
  output logic             O_WAIT,
  output logic             O_WAIT_OE,
  // Array port
  input  wire logic [15:0] I_MEM_RDATA,
  output logic             O_MEM_WE,
  output logic      [22:0] O_MEM_ADDR,
  output logic      [15:0] O_MEM_WDATA,
  output logic      [1:0]  O_MEM_BE,
  // Status
  output logic             O_READY,
  output logic             O_DEEP_POWER_DOWN,
  output logic             O_BURST_MODE,
  output logic             O_PAGE_MODE
);

  // ==========================================
  // Parameter checks
  // Larger values would overflow the narrow counters held in the state struct.
  if (INIT_CYCLES < 1 || INIT_CYCLES > 16383 || ACCESS_CYCLES < 1 || ACCESS_CYCLES > 15 ||
      PAGE_CYCLES < 1 || PAGE_CYCLES > ACCESS_CYCLES) begin : g_param_check
    $error("psb_iface: unsupported timing parameters.");
  end

  // ==========================================
  // State
  psb_pkg::psb_regs_t r_reg;
  psb_pkg::psb_regs_t r_next;
  psb_pkg::psb_ctrl_t c;
  psb_pkg::psb_ctrl_t c_d_reg;
  logic [15:0]        lane_mask;
  logic               rd_req;
  logic               wr_act;
  logic               wr_end;
  logic               page_hit;

  function automatic logic [1:0] lanes(input psb_pkg::psb_ctrl_t s);
    lanes = {~s.high_byte_sel_n, ~s.low_byte_sel_n};
  endfunction

  assign c = '{I_CE_N, I_OE_N, I_WE_N, I_LOW_BYTE_SEL_N, I_HIGH_BYTE_SEL_N, I_ADDR_VALID_N, I_CFG_REG_SELECT};
  assign rd_req = !c.ce_n && !c.oe_n && c.we_n && (lanes(c) != 2'h0);
  assign wr_act = !c.ce_n && !c.we_n && (lanes(c) != 2'h0 || c.cfg_reg_select);
  // A rise of CE or WE, or of the last low byte enable in an array write, ends the write; the held copy keeps the pre-edge data.
  assign wr_end = r_reg.state == psb_pkg::PSB_ST_WRITE && !wr_act;
  assign page_hit = r_reg.page_open && r_reg.refresh_config[`PSB_RCR_PAGE_BIT] &&
                    I_ADDR[22:4] == r_reg.addr[22:4];
  assign lane_mask = {{8{r_reg.wlanes[1]}}, {8{r_reg.wlanes[0]}}};

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      c_d_reg <= '1;
    end else begin
      c_d_reg <= c;
    end
  end

  // ==========================================
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.mem_we = 1'b0;
    case (r_reg.state)
      psb_pkg::PSB_ST_INIT: begin
        r_next.init_cnt = r_reg.init_cnt + 14'h0001;
        if (r_reg.init_cnt == 14'(INIT_CYCLES - 1)) begin
          r_next.bus_config     = `PSB_BCR_RESET;
          r_next.refresh_config = `PSB_RCR_RESET;
          r_next.ready          = 1'b1;
          r_next.state          = psb_pkg::PSB_ST_IDLE;
        end
      end
      psb_pkg::PSB_ST_IDLE: begin
        r_next.acc_cnt = 4'h0;
        if (c.ce_n) begin
          r_next.page_open = 1'b0;
        end else if (wr_act) begin
          r_next.page_open = 1'b0;
          r_next.state     = psb_pkg::PSB_ST_WRITE;
        end else if (rd_req) begin
          r_next.state = psb_pkg::PSB_ST_READ;
        end
      end
      psb_pkg::PSB_ST_READ: begin
        r_next.acc_cnt = r_reg.acc_cnt + 4'h1;
        if (!rd_req) begin
          r_next.dq_oe = 2'h0;
          r_next.state = psb_pkg::PSB_ST_IDLE;
        end else if (I_ADDR != r_reg.addr) begin
          r_next.acc_cnt = 4'h0;
          r_next.dq_oe   = 2'h0;
          if (!page_hit) begin
            r_next.page_open = 1'b0;
          end
        end else if (r_reg.acc_cnt >= 4'(page_hit ? PAGE_CYCLES - 1 : ACCESS_CYCLES - 1)) begin
          r_next.dq_o      = I_MEM_RDATA;
          r_next.dq_oe     = lanes(c);
          r_next.page_open = 1'b1;
        end
        if (wr_act) begin
          r_next.dq_oe = 2'h0;
          r_next.state = psb_pkg::PSB_ST_WRITE;
        end
      end
      psb_pkg::PSB_ST_WRITE: begin
        r_next.dq_oe = 2'h0;
        if (wr_act) begin
          r_next.wdata  = I_DQ;
          r_next.wlanes = lanes(c);
          r_next.wcfg   = c.cfg_reg_select;
        end else begin
          r_next.state = psb_pkg::PSB_ST_IDLE;
          if (r_reg.wcfg) begin
            if (r_reg.addr[`PSB_CFG_SEL_LSB +: 2] == `PSB_CFG_SEL_BCR) begin
              r_next.bus_config = r_reg.addr[15:0];
            end else begin
              r_next.refresh_config = r_reg.addr[15:0];
            end
          end else if (r_reg.wlanes != 2'h0) begin
            r_next.mem_we    = 1'b1;
            r_next.mem_addr  = r_reg.addr;
            r_next.mem_wdata = r_reg.wdata & lane_mask;
            r_next.mem_be    = r_reg.wlanes;
          end
        end
      end
      psb_pkg::PSB_ST_DPD: begin
        r_next.page_open = 1'b0;
        if (wr_act && c.cfg_reg_select) begin
          r_next.state = psb_pkg::PSB_ST_WRITE;
        end
      end
      default: r_next.state = psb_pkg::PSB_ST_INIT;
    endcase
    // Address is caught on the rising edge of address valid or followed while it is low.
    if (!c.addr_valid_n || (c.addr_valid_n && !c_d_reg.addr_valid_n)) begin
      if (r_reg.state != psb_pkg::PSB_ST_WRITE || wr_act) begin
        r_next.addr = I_ADDR;
      end
    end
    // Deep power-down is entered at deselect when the refresh register requests it.
    if (r_reg.state == psb_pkg::PSB_ST_IDLE && c.ce_n &&
        r_reg.refresh_config[`PSB_RCR_DPD_BIT] == 1'b0) begin
      r_next.state = psb_pkg::PSB_ST_DPD;
    end
    if (r_next.state == psb_pkg::PSB_ST_DPD && wr_end) begin
      r_next.state = psb_pkg::PSB_ST_IDLE;
    end
    // Wait is driven, at the configured polarity, while selected; its level carries no meaning here.
    r_next.wait_oe = !c.ce_n && r_reg.ready && r_next.state != psb_pkg::PSB_ST_DPD;
    r_next.wait_o  = r_reg.bus_config[`PSB_BCR_WAIT_POL_BIT];
    if (c.ce_n || r_next.state == psb_pkg::PSB_ST_DPD) begin
      r_next.dq_oe = 2'h0;
    end
    // A new select always starts with a full access, so deselect closes the open page.
    if (c.ce_n) begin
      r_next.page_open = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      r_reg       <= '0;
      r_reg.state <= psb_pkg::PSB_ST_INIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================
  // Outputs
  assign O_DQ              = r_reg.dq_o;
  assign O_DQ_OE           = r_reg.dq_oe;
  assign O_WAIT            = r_reg.wait_o;
  assign O_WAIT_OE         = r_reg.wait_oe;
  assign O_MEM_WE          = r_reg.mem_we;
  assign O_MEM_ADDR        = r_reg.mem_addr;
  assign O_MEM_WDATA       = r_reg.mem_wdata;
  assign O_MEM_BE          = r_reg.mem_be;
  assign O_READY           = r_reg.ready;
  assign O_DEEP_POWER_DOWN = r_reg.state == psb_pkg::PSB_ST_DPD;
  assign O_BURST_MODE      = r_reg.ready && !r_reg.bus_config[`PSB_BCR_BURST_BIT];
  assign O_PAGE_MODE       = r_reg.refresh_config[`PSB_RCR_PAGE_BIT];

  // ==========================================
  // Checks
  sequence s_write_done;
    r_reg.state == psb_pkg::PSB_ST_WRITE && !wr_act && !r_reg.wcfg && r_reg.wlanes != 2'h0;
  endsequence

  write_commit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    s_write_done |=> O_MEM_WE && O_MEM_BE == $past(r_reg.wlanes)) else $error("Write not committed.");
  write_nodrive_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    r_reg.state == psb_pkg::PSB_ST_WRITE |-> O_DQ_OE == 2'h0) else $error("Data driven in write.");
  standby_float_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $past(I_CE_N) |-> !O_DQ_OE[0] && !O_DQ_OE[1] && !O_WAIT_OE) else $error("Outputs driven in standby.");
  init_ready_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(O_READY) |-> r_reg.bus_config == `PSB_BCR_RESET && r_reg.refresh_config == `PSB_RCR_RESET)
    else $error("Ready without defaults.");
  lane_select_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(O_DQ_OE != 2'h0) |-> O_DQ_OE == $past(lanes(c))) else $error("Wrong lanes driven.");
  read_latency_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $rose(O_DQ_OE != 2'h0) && !$past(page_hit) |-> $past(r_reg.acc_cnt) >= 4'(ACCESS_CYCLES - 1))
    else $error("Read data too early.");
  wait_polarity_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_WAIT_OE |-> O_WAIT == $past(r_reg.bus_config[`PSB_BCR_WAIT_POL_BIT])) else $error("Wait polarity wrong.");
  dpd_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_DEEP_POWER_DOWN && !(wr_act && c.cfg_reg_select) |=> O_DEEP_POWER_DOWN) else $error("Left power-down.");
  no_lane_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    O_MEM_WE |-> O_MEM_BE != 2'h0) else $error("Write with no lanes.");
endmodule

// ===== rtl/psb_map.svh
// Constants of the pseudo-static RAM bus interface.
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH
// ==========================================
// Timing
`define PSB_INIT_TIME_US      150
`define PSB_CLK_MHZ           100
`define PSB_INIT_CYCLES       (`PSB_INIT_TIME_US * `PSB_CLK_MHZ)
`define PSB_ACCESS_CYCLES     7
`define PSB_PAGE_CYCLES       3
// ==========================================
// Configuration register fields and reset values
`define PSB_BCR_BURST_BIT     15
`define PSB_BCR_WAIT_POL_BIT  10
`define PSB_RCR_PAGE_BIT      7
`define PSB_RCR_DPD_BIT       4
`define PSB_BCR_RESET         16'h9D1F
`define PSB_RCR_RESET         16'h0010
// ==========================================
// Configuration register select on the upper address bits
`define PSB_CFG_SEL_LSB       18
`define PSB_CFG_SEL_RCR       2'h0
`define PSB_CFG_SEL_BCR       2'h2
`endif

// ===== rtl/psb_pkg.sv
// Types of the pseudo-static RAM bus interface.
package psb_pkg;
  // ==========================================
  // Controller state
  typedef enum logic [4:0] {
    PSB_ST_INIT  = 5'h01,
    PSB_ST_IDLE  = 5'h02,
    PSB_ST_READ  = 5'h04,
    PSB_ST_WRITE = 5'h08,
    PSB_ST_DPD   = 5'h10
  } psb_state_t;

  // Strobes from the controller, all active low except the active-high configuration register select.
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic low_byte_sel_n;
    logic high_byte_sel_n;
    logic addr_valid_n;
    logic cfg_reg_select;
  } psb_ctrl_t;

  typedef struct packed {
    psb_state_t  state;
    logic [13:0] init_cnt;
    logic [3:0]  acc_cnt;
    logic [22:0] addr;
    logic        page_open;
    logic [15:0] bus_config;
    logic [15:0] refresh_config;
    logic [15:0] wdata;
    logic [1:0]  wlanes;
    logic        wcfg;
    logic [15:0] dq_o;
    logic [1:0]  dq_oe;
    logic        wait_o;
    logic        wait_oe;
    logic        mem_we;
    logic [22:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [1:0]  mem_be;
    logic        ready;
  } psb_regs_t;
endpackage

// ===== verification/psb_ctrl_model.sv
// Controller model that drives strobes, address and data toward the device.
`timescale 1ns/1ps
module psb_ctrl_model (
  // Clock and device feedback
  input  wire logic                 i_clk,
  input  wire logic          [1:0]  i_dq_oe,
  // Bus toward the device
  output psb_pkg::psb_ctrl_t        o_ctrl,
  output logic               [22:0] o_addr,
  output logic               [15:0] o_dq
);
  // ==========================================
  // Idle bus
  // Address valid stays low for every access, so no pulse timing is needed.
  // The model takes the bench clock on i_clk and changes the bus only on its falling edges.
  initial begin
    o_ctrl = 7'h7C;
    o_addr = 23'h0;
    o_dq   = 16'h0;
  end

  task automatic drive(input logic [6:0] c, input logic [22:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_ctrl = c;
    o_addr = a;
    o_dq   = d;
  endtask

  // ==========================================
  // Write
  // WE rises a cycle before CE and the data flips with it, so a capture at the wrong edge shows.
  task automatic wr(input logic [22:0] a, input logic [15:0] d, input logic [1:0] s, input logic cfg);
    drive({1'b0, cfg, 1'b0, s[0], s[1], 1'b0, cfg}, a, d);
    repeat (3) @(negedge i_clk);
    drive({1'b0, cfg, 1'b1, s[0], s[1], 1'b0, cfg}, a, ~d);
    drive(7'h7C, a, ~d);
    drive(7'h7C, a, d);
  endtask

  // ==========================================
  // Read
  // The wait pin is never looked at: its level carries nothing here.
  task automatic rd(input logic [22:0] a, input logic [1:0] s, input logic keep, output int n);
    drive({3'b001, s[0], s[1], 2'b00}, a, ~o_dq);
    n = 0;
    while (i_dq_oe !== 2'h0 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    while (i_dq_oe === 2'h0 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    if (!keep) drive(7'h7C, a, ~o_dq);
  endtask
endmodule

// ===== verification/psram_async_page_bus_interface_tb_top.sv
// Self-checking bench of the pseudo-static RAM bus interface.
`timescale 1ns/1ps
`include "psb_map.svh"
module psram_async_page_bus_interface_tb_top;
  // ==========================================
  // Wiring and bookkeeping
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  psb_pkg::psb_ctrl_t ctrl;
  logic        [22:0] addr, mem_addr;
  logic        [15:0] dq_in, dq_out, mem_rdata, mem_wdata;
  logic        [1:0]  dq_oe, mem_be, oe_q = 2'h0;
  logic               wt, wt_oe, mem_we, ready, deep_power_down, burst, page;
  logic        [15:0] mem [256], sh [256];
  logic        [40:0] wq [$];
  logic        [17:0] rq [$];
  logic        [63:0] e;
  int                 n_mismatch = 0, check_count = 0, seed = 32'h12A90336, n0, n1, n2, k;

  initial forever #5 clk = ~clk;
  initial for (int i = 0; i < 256; i++) begin
    mem[i] = 16'h0;
    sh[i]  = 16'h0;
  end
  assign mem_rdata = mem[addr[7:0]];
  always @(posedge clk) if (mem_we) begin
    if (mem_be[0]) mem[mem_addr[7:0]][7:0] <= mem_wdata[7:0];
    if (mem_be[1]) mem[mem_addr[7:0]][15:8] <= mem_wdata[15:8];
  end

  psb_ctrl_model i_psb_ctrl_model (.i_clk(clk), .i_dq_oe(dq_oe), .o_ctrl(ctrl), .o_addr(addr), .o_dq(dq_in));
  psb_iface #(.INIT_CYCLES(20)) i_psb_iface (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE_N(ctrl.ce_n), .I_OE_N(ctrl.oe_n), .I_WE_N(ctrl.we_n),
    .I_LOW_BYTE_SEL_N(ctrl.low_byte_sel_n), .I_HIGH_BYTE_SEL_N(ctrl.high_byte_sel_n),
    .I_ADDR_VALID_N(ctrl.addr_valid_n), .I_CFG_REG_SELECT(ctrl.cfg_reg_select), .I_ADDR(addr),
    .I_DQ(dq_in), .O_DQ(dq_out), .O_DQ_OE(dq_oe), .O_WAIT(wt), .O_WAIT_OE(wt_oe),
    .I_MEM_RDATA(mem_rdata), .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata),
    .O_MEM_BE(mem_be), .O_READY(ready), .O_DEEP_POWER_DOWN(deep_power_down), .O_BURST_MODE(burst), .O_PAGE_MODE(page));

  // ==========================================
  // Checking
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // A pulse or data rise with no note queued fails against the all-ones sentinel.
  always @(negedge clk) begin
    oe_q <= dq_oe;
    if (rst_n && !ctrl.ce_n && !ctrl.we_n) chk("dq_oe_wr", dq_oe, 0);
    if (mem_we === 1'b1) begin
      e = (wq.size() > 0) ? wq.pop_front() : '1;
      chk("mem_wr", {mem_addr, mem_be, mem_wdata}, e);
    end
    if (dq_oe !== 2'h0 && oe_q === 2'h0) begin
      e = (rq.size() > 0) ? rq.pop_front() : '1;
      chk("rd", {dq_oe, dq_out & {{8{dq_oe[1]}}, {8{dq_oe[0]}}}}, e);
    end
  end

  // ==========================================
  // Stimulus
  task automatic wrx(input logic [22:0] a, input logic [15:0] d, input logic [1:0] s);
    logic [15:0] m;
    m = {{8{~s[1]}}, {8{~s[0]}}};
    wq.push_back({a, ~s, d & m});
    sh[a[7:0]] = (sh[a[7:0]] & ~m) | (d & m);
    i_psb_ctrl_model.wr(a, d, s, 1'b0);
  endtask
  task automatic rdx(input logic [22:0] a, input logic [1:0] s, input logic keep, output int n);
    rq.push_back({~s, sh[a[7:0]] & {{8{~s[1]}}, {8{~s[0]}}}});
    i_psb_ctrl_model.rd(a, s, keep, n);
    tmo(n);
  endtask

  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk("ready", ready, 0);
    repeat (10) @(negedge clk);
    chk("ready", ready, 0);
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(negedge clk);
    tmo(k);
    chk("modes", {burst, page, deep_power_down}, 0);
    for (k = 0; k < 6; k++) begin
      wrx(23'(k * 37), 16'($random(seed)), 2'(k % 3));
      rdx(23'(k * 37), 2'(k % 3), 1'b0, n0);
      rdx(23'(k * 37), 2'h0, 1'b0, n0);
    end
    i_psb_ctrl_model.wr(23'h5, 16'hFFFF, 2'h3, 1'b0);
    i_psb_ctrl_model.rd(23'h5, 2'h3, 1'b0, n0);
    chk("no_lane_rd", n0, 40);
    rdx(23'h5, 2'h0, 1'b1, n0);
    chk("wait", {wt_oe, wt}, 2'h3);
    i_psb_ctrl_model.drive(7'h7C, 23'h5, 16'h0);
    @(negedge clk);
    chk("standby", {wt_oe, dq_oe}, 0);
    i_psb_ctrl_model.wr(23'h90, 16'h0, 2'h3, 1'b1);
    chk("page", page, 1);
    for (k = 0; k < 3; k++) wrx(23'(8'h40 + k * 7), 16'($random(seed)), 2'h0);
    rdx(23'h40, 2'h0, 1'b1, n0);
    rdx(23'h47, 2'h0, 1'b1, n1);
    rdx(23'h4E, 2'h0, 1'b0, n2);
    chk("page_fast", n1 < n0 && n2 < n0, 1);
    chk("page_hit", n2, `PSB_PAGE_CYCLES + 1);
    // A fresh select in the same page pays the full access time again.
    rdx(23'h41, 2'h0, 1'b0, n1);
    chk("page_new", n1, `PSB_ACCESS_CYCLES + 1);
    i_psb_ctrl_model.wr(23'h81D1F, 16'h0, 2'h3, 1'b1);
    chk("burst", burst, 1);
    // This value also turns the wait polarity over.
    i_psb_ctrl_model.wr(23'h8991F, 16'h0, 2'h3, 1'b1);
    chk("cfg", {burst, page}, 2'h1);
    i_psb_ctrl_model.wr(23'h80, 16'h0, 2'h3, 1'b1);
    chk("dpd", {deep_power_down, dq_oe, wt_oe}, 4'h8);
    i_psb_ctrl_model.wr(23'h90, 16'h0, 2'h3, 1'b1);
    chk("dpd", deep_power_down, 0);
    wrx(23'h9, 16'($random(seed)), 2'h0);
    rdx(23'h9, 2'h0, 1'b1, n0);
    chk("wait_pol", {wt_oe, wt}, 2'h2);
    stop_test();
  end
endmodule
